// file: rtl/bertc_consts.vh
// Register offsets, field positions and reset values of the bit-error-rate tester
`ifndef BERTC_CONSTS_VH
`define BERTC_CONSTS_VH

`define BERTC_ADR_STATUS     8'h26
`define BERTC_ADR_ALT_COUNT  8'hdb
`define BERTC_ADR_CTRL_ONE   8'he0
`define BERTC_ADR_PAT0       8'hdc
`define BERTC_ADR_PAT1       8'hdd
`define BERTC_ADR_PAT2       8'hde
`define BERTC_ADR_PAT3       8'hdf
`define BERTC_ADR_BITC0      8'he3
`define BERTC_ADR_BITC1      8'he4
`define BERTC_ADR_BITC2      8'he5
`define BERTC_ADR_BITC3      8'he6
`define BERTC_ADR_ERRC0      8'he7
`define BERTC_ADR_ERRC1      8'he8
`define BERTC_ADR_ERRC2      8'he9
`define BERTC_ADR_IFC        8'hea

`define BERTC_IFC_ENABLE     0
`define BERTC_IFC_DIRECTION  1
`define BERTC_IFC_TX_UNFR    3
`define BERTC_IFC_TX_ALIGN   4
`define BERTC_IFC_RX_UNFR    6

`define BERTC_C1_LATCH       0
`define BERTC_C1_MODE_LO     2
`define BERTC_C1_MODE_HI     3

`define BERTC_ST_SYNC        0
`define BERTC_ST_ERR_OVF     4
`define BERTC_ST_BIT_OVF     5

`define BERTC_MODE_REPEAT    2'h0
`define BERTC_MODE_PRBS      2'h1
`define BERTC_MODE_ALT       2'h2

`define BERTC_SYNC_MATCHES   6'h20
`define BERTC_RESET_BYTE     8'h00

`endif

// file: rtl/bertc_core.v
// Bit-error-rate tester core: pattern generator, checker, counters and byte registers
// Notes on behaviour
// - 32-bit pattern in four bytes, low byte first
// - Pattern bit 0 sent and compared first
// - Alternating words: low half first, high second
// - Bit counter counts every bit once synchronized
// - Bit counter saturates, sets its overflow flag
// - Latch-counters rising edge clears both counters
// - Bit counter readable as four bytes
// - Error counter counts mismatches once synchronized
// - Error counter saturates, sets its overflow flag
// - Error counter readable as three bytes
// - Interface control bit 0 enables tester
// - Direction zero uses line transmit and receive
// - Direction one uses backplane serial paths
// - Line direction loops pattern back on loopback
// - Control bit 3 lets pattern fill frame bits
// - Rising control bit 4 byte-aligns the generator
// - Control bit 6 passes frame bits to checker
// - Sync after 32 consecutive matching bits
// - Overflow flags latch, clear on read
// - Each alternating word repeats count times, a count of zero as one
`timescale 1ns/1ns
`default_nettype none
`include "bertc_consts.vh"

module bertc_core (
	input  wire       CLK_SYS,
	input  wire       SRST,
	input  wire [7:0] REG_ADDR,
	input  wire       REG_WR,
	input  wire       REG_RD,
	input  wire [7:0] REG_WDATA,
	output reg  [7:0] REG_RDATA,
	input  wire       LOOPBACK_EN,
	input  wire       TX_FBIT_SLOT,
	input  wire       TX_BYTE_START,
	output wire       LINE_TX_DATA,
	output wire       LINE_TX_VALID,
	input  wire       LINE_TX_READY,
	output wire       BACKPLANE_RX_SERIAL_OUT,
	output wire       BACKPLANE_RX_VALID,
	input  wire       BACKPLANE_RX_READY,
	input  wire       LINE_RX_DATA,
	input  wire       LINE_RX_STROBE,
	input  wire       BACKPLANE_TX_SERIAL_IN,
	input  wire       BACKPLANE_TX_STROBE,
	input  wire       RX_FBIT_SLOT,
	output wire       CHECKER_IN_SYNC
);

	// Registers
	reg  [31:0] pattern_q;
	reg  [7:0]  alt_count_q;
	reg  [7:0]  ctrl_one_q;
	reg  [7:0]  ifc_q;
	reg  [31:0] bit_count_q;
	reg  [23:0] err_count_q;
	reg         bit_ovf_q;
	reg         err_ovf_q;
	reg         latch_prev_q;
	reg         align_prev_q;
	reg         enable_prev_q;

	wire [1:0] mode          = ctrl_one_q[`BERTC_C1_MODE_HI:`BERTC_C1_MODE_LO];
	wire       tester_enable = ifc_q[`BERTC_IFC_ENABLE];
	wire       tester_dir    = ifc_q[`BERTC_IFC_DIRECTION];
	wire       tx_unframed   = ifc_q[`BERTC_IFC_TX_UNFR];
	wire       rx_unframed   = ifc_q[`BERTC_IFC_RX_UNFR];

	// Pattern bit for a position; alternating words use 16 bits each
	function patbit;
		input [31:0] pat;
		input [1:0]  md;
		input [4:0]  idx;
		input        word;
		begin
			if (md == `BERTC_MODE_ALT) begin
				patbit = pat[{word, idx[3:0]}];
			end else begin
				patbit = pat[idx];
			end
		end
	endfunction

	// Advances position, repeat count and word select by one bit
	function [13:0] next_pos;
		input [1:0] md;
		input [4:0] idx;
		input [7:0] rep;
		input       word;
		input [7:0] limit;
		reg   [7:0] lim;
		begin
			lim = (limit == 8'h00) ? 8'h01 : limit;
			next_pos = {word, rep, idx + 5'h01};
			if (md == `BERTC_MODE_ALT && idx[3:0] == 4'hf) begin
				if (rep + 8'h01 >= lim) begin
					next_pos = {~word, 8'h00, 5'h00};
				end else begin
					next_pos = {word, rep + 8'h01, 5'h00};
				end
			end
		end
	endfunction

	// Register writes and edge-triggered controls
	wire latch_rise = ctrl_one_q[`BERTC_C1_LATCH] & ~latch_prev_q;
	wire align_rise = ifc_q[`BERTC_IFC_TX_ALIGN] & ~align_prev_q;
	wire enable_rise = tester_enable & ~enable_prev_q;

	always @(posedge CLK_SYS) begin
		if (SRST) begin
			pattern_q     <= 32'h00000000;
			alt_count_q   <= `BERTC_RESET_BYTE;
			ctrl_one_q    <= `BERTC_RESET_BYTE;
			ifc_q         <= `BERTC_RESET_BYTE;
			latch_prev_q  <= 1'b0;
			align_prev_q  <= 1'b0;
			enable_prev_q <= 1'b0;
		end else begin
			latch_prev_q  <= ctrl_one_q[`BERTC_C1_LATCH];
			align_prev_q  <= ifc_q[`BERTC_IFC_TX_ALIGN];
			enable_prev_q <= tester_enable;
			if (REG_WR) begin
				case (REG_ADDR)
				`BERTC_ADR_PAT0: pattern_q[7:0]   <= REG_WDATA;
				`BERTC_ADR_PAT1: pattern_q[15:8]  <= REG_WDATA;
				`BERTC_ADR_PAT2: pattern_q[23:16] <= REG_WDATA;
				`BERTC_ADR_PAT3: pattern_q[31:24] <= REG_WDATA;
				`BERTC_ADR_ALT_COUNT: alt_count_q <= REG_WDATA;
				`BERTC_ADR_CTRL_ONE: ctrl_one_q   <= REG_WDATA;
				`BERTC_ADR_IFC: ifc_q             <= REG_WDATA;
				default: ;
				endcase
			end
		end
	end

	// Generator with byte alignment
	reg  [4:0] tidx_q;
	reg  [7:0] trep_q;
	reg        tword_q;
	reg  [8:0] tlfsr_q;
	reg        align_pend_q;
	reg  [1:0] buf_cnt_q;
	reg        buf0_q;
	reg        buf1_q;

	wire gen_bit   = (mode == `BERTC_MODE_PRBS) ? tlfsr_q[8] :
	                 patbit(pattern_q, mode, tidx_q, tword_q);
	// The restart edge pushes nothing, so pattern bit 0 leads the stream
	wire gen_valid = tester_enable & ~align_pend_q & ~enable_rise;
	wire buf_ready = (buf_cnt_q != 2'h2);
	wire push      = gen_valid & buf_ready;
	wire out_valid = tester_enable & (buf_cnt_q != 2'h0) &
	                 (tx_unframed | ~TX_FBIT_SLOT);
	wire sink_ready = tester_dir ? BACKPLANE_RX_READY : LINE_TX_READY;
	wire pop       = out_valid & sink_ready;
	wire restart   = enable_rise | (align_pend_q & TX_BYTE_START);
	wire [13:0] tnext = next_pos(mode, tidx_q, trep_q, tword_q, alt_count_q);

	always @(posedge CLK_SYS) begin
		if (SRST) begin
			tidx_q       <= 5'h00;
			trep_q       <= 8'h00;
			tword_q      <= 1'b0;
			tlfsr_q      <= 9'h000;
			align_pend_q <= 1'b0;
		end else begin
			if (align_rise) begin
				align_pend_q <= 1'b1;
			end else if (TX_BYTE_START) begin
				align_pend_q <= 1'b0;
			end
			if (restart | align_rise) begin
				tidx_q  <= 5'h00;
				trep_q  <= 8'h00;
				tword_q <= 1'b0;
				tlfsr_q <= pattern_q[8:0];
			end else if (push) begin
				{tword_q, trep_q, tidx_q} <= tnext;
				tlfsr_q <= {tlfsr_q[7:0], tlfsr_q[8] ^ tlfsr_q[4]};
			end
		end
	end

	// Two-entry buffer between generator and the selected sink
	// Flushed while disabled or on an align request
	always @(posedge CLK_SYS) begin
		if (SRST) begin
			buf_cnt_q <= 2'h0;
			buf0_q    <= 1'b0;
			buf1_q    <= 1'b0;
		end else if (~tester_enable | align_rise) begin
			buf_cnt_q <= 2'h0;
		end else begin
			case ({push, pop})
			2'b10: begin
				if (buf_cnt_q == 2'h0) begin
					buf0_q <= gen_bit;
				end else begin
					buf1_q <= gen_bit;
				end
				buf_cnt_q <= buf_cnt_q + 2'h1;
			end
			2'b01: begin
				buf0_q    <= buf1_q;
				buf_cnt_q <= buf_cnt_q - 2'h1;
			end
			2'b11: begin
				if (buf_cnt_q == 2'h1) begin
					buf0_q <= gen_bit;
				end else begin
					buf0_q <= buf1_q;
					buf1_q <= gen_bit;
				end
			end
			default: ;
			endcase
		end
	end

	assign LINE_TX_DATA            = buf0_q;
	assign LINE_TX_VALID           = out_valid & ~tester_dir;
	assign BACKPLANE_RX_SERIAL_OUT = buf0_q;
	assign BACKPLANE_RX_VALID      = out_valid & tester_dir;

	// Receive source selection
	reg  rx_bit;
	reg  rx_stb;
	always @* begin
		if (tester_dir) begin
			rx_bit = BACKPLANE_TX_SERIAL_IN;
			rx_stb = BACKPLANE_TX_STROBE;
		end else if (LOOPBACK_EN) begin
			rx_bit = buf0_q;
			rx_stb = pop;
		end else begin
			rx_bit = LINE_RX_DATA;
			rx_stb = LINE_RX_STROBE;
		end
	end

	wire rx_take = tester_enable & rx_stb & (rx_unframed | ~RX_FBIT_SLOT);

	// Checker
	reg  [4:0] ridx_q;
	reg  [7:0] rrep_q;
	reg        rword_q;
	reg  [8:0] rlfsr_q;
	reg  [5:0] match_q;
	reg        sync_q;

	wire exp_bit = (mode == `BERTC_MODE_PRBS) ? (rlfsr_q[8] ^ rlfsr_q[4]) :
	               patbit(pattern_q, mode, ridx_q, rword_q);
	wire bit_ok  = (rx_bit == exp_bit);
	wire [13:0] rnext = next_pos(mode, ridx_q, rrep_q, rword_q, alt_count_q);

	always @(posedge CLK_SYS) begin
		if (SRST | ~tester_enable) begin
			ridx_q  <= 5'h00;
			rrep_q  <= 8'h00;
			rword_q <= 1'b0;
			rlfsr_q <= 9'h000;
			match_q <= 6'h00;
			sync_q  <= 1'b0;
		end else if (rx_take) begin
			if (mode == `BERTC_MODE_PRBS) begin
				rlfsr_q <= {rlfsr_q[7:0], sync_q ? exp_bit : rx_bit};
			end
			if (sync_q | bit_ok | (mode == `BERTC_MODE_PRBS)) begin
				{rword_q, rrep_q, ridx_q} <= rnext;
			end
			if (~sync_q) begin
				if (~bit_ok) begin
					match_q <= 6'h00;
				end else if (match_q + 6'h01 == `BERTC_SYNC_MATCHES) begin
					sync_q <= 1'b1;
				end else begin
					match_q <= match_q + 6'h01;
				end
			end
		end
	end

	assign CHECKER_IN_SYNC = sync_q;

	// Counters and overflow flags
	wire status_read = REG_RD & (REG_ADDR == `BERTC_ADR_STATUS);
	wire bit_inc = rx_take & sync_q & (bit_count_q != 32'hffffffff);
	wire err_inc = rx_take & sync_q & ~bit_ok & (err_count_q != 24'hffffff);
	wire bit_hit = bit_inc & (bit_count_q == 32'hfffffffe);
	wire err_hit = err_inc & (err_count_q == 24'hfffffe);

	always @(posedge CLK_SYS) begin
		if (SRST) begin
			bit_count_q <= 32'h00000000;
			err_count_q <= 24'h000000;
			bit_ovf_q   <= 1'b0;
			err_ovf_q   <= 1'b0;
		end else begin
			if (latch_rise) begin
				bit_count_q <= 32'h00000000;
				err_count_q <= 24'h000000;
			end else begin
				if (bit_inc) begin
					bit_count_q <= bit_count_q + 32'h00000001;
				end
				if (err_inc) begin
					err_count_q <= err_count_q + 24'h000001;
				end
			end
			if (bit_hit) begin
				bit_ovf_q <= 1'b1;
			end else if (status_read) begin
				bit_ovf_q <= 1'b0;
			end
			if (err_hit) begin
				err_ovf_q <= 1'b1;
			end else if (status_read) begin
				err_ovf_q <= 1'b0;
			end
		end
	end

	// Read data, registered on the read strobe
	reg [7:0] rd_mux;
	always @* begin
		rd_mux = 8'h00;
		case (REG_ADDR)
		`BERTC_ADR_STATUS: begin
			rd_mux[`BERTC_ST_SYNC]    = sync_q;
			rd_mux[`BERTC_ST_ERR_OVF] = err_ovf_q;
			rd_mux[`BERTC_ST_BIT_OVF] = bit_ovf_q;
		end
		`BERTC_ADR_ALT_COUNT: rd_mux = alt_count_q;
		`BERTC_ADR_CTRL_ONE: rd_mux  = ctrl_one_q;
		`BERTC_ADR_PAT0: rd_mux      = pattern_q[7:0];
		`BERTC_ADR_PAT1: rd_mux      = pattern_q[15:8];
		`BERTC_ADR_PAT2: rd_mux      = pattern_q[23:16];
		`BERTC_ADR_PAT3: rd_mux      = pattern_q[31:24];
		`BERTC_ADR_BITC0: rd_mux     = bit_count_q[7:0];
		`BERTC_ADR_BITC1: rd_mux     = bit_count_q[15:8];
		`BERTC_ADR_BITC2: rd_mux     = bit_count_q[23:16];
		`BERTC_ADR_BITC3: rd_mux     = bit_count_q[31:24];
		`BERTC_ADR_ERRC0: rd_mux     = err_count_q[7:0];
		`BERTC_ADR_ERRC1: rd_mux     = err_count_q[15:8];
		`BERTC_ADR_ERRC2: rd_mux     = err_count_q[23:16];
		`BERTC_ADR_IFC: rd_mux       = ifc_q;
		default: rd_mux = 8'h00;
		endcase
	end

	always @(posedge CLK_SYS) begin
		if (SRST) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			REG_RDATA <= rd_mux;
		end
	end

endmodule // bertc_core

`default_nettype wire

// file: tb/bertc_checker.sv
// Port checker for the bit-error-rate tester core
`timescale 1ns/1ns
`default_nettype none
`include "bertc_consts.vh"
module bertc_checker (
	input wire logic       CLK_SYS,
	input wire logic       SRST,
	input wire logic [7:0] REG_ADDR,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic       LOOPBACK_EN,
	input wire logic       TX_FBIT_SLOT,
	input wire logic       LINE_TX_VALID,
	input wire logic       BACKPLANE_RX_VALID,
	input wire logic       LINE_RX_STROBE,
	input wire logic       BACKPLANE_TX_STROBE,
	input wire logic       RX_FBIT_SLOT,
	input wire logic       CHECKER_IN_SYNC
);
	logic [7:0] ifc_q;
	logic [5:0] taken_q;
	logic       take;
	logic       mapped;
	assign take = ifc_q[0] && (ifc_q[1] ? BACKPLANE_TX_STROBE : LINE_RX_STROBE)
		&& (!RX_FBIT_SLOT || ifc_q[6]);
	assign mapped = (REG_ADDR >= 8'hdb && REG_ADDR <= 8'hea && REG_ADDR != 8'he1
		&& REG_ADDR != 8'he2) || REG_ADDR == `BERTC_ADR_STATUS;
	// Shadow of the interface control and count of bits taken since enable
	always @(posedge CLK_SYS) begin
		if (SRST) begin
			ifc_q <= 8'h00;
		end else if (REG_WR && REG_ADDR == `BERTC_ADR_IFC) begin
			ifc_q <= REG_WDATA;
		end
	end
	always @(posedge CLK_SYS) begin
		if (SRST || !ifc_q[0]) begin
			taken_q <= 6'h00;
		end else if (take && taken_q != 6'h3f) begin
			taken_q <= taken_q + 6'h01;
		end
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	AST_LINE_VALID: assert property (LINE_TX_VALID |-> ifc_q[0] && !ifc_q[1])
		else $error("line valid out of mode");
	AST_BP_VALID: assert property (BACKPLANE_RX_VALID |-> ifc_q[0] && ifc_q[1])
		else $error("backplane valid out of mode");
	AST_TX_FRAMED: assert property (TX_FBIT_SLOT && !ifc_q[3] |-> !LINE_TX_VALID)
		else $error("pattern in frame bit");
	AST_SYNC_COUNT: assert property ($rose(CHECKER_IN_SYNC) && !LOOPBACK_EN |-> taken_q >= 6'h20)
		else $error("sync before 32 bits");
	AST_SYNC_OFF: assert property (!ifc_q[0] && !$past(ifc_q[0]) |-> !CHECKER_IN_SYNC)
		else $error("sync while disabled");
	AST_UNMAPPED: assert property (REG_RD && !mapped |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	AST_IFC_READ: assert property (REG_RD && REG_ADDR == `BERTC_ADR_IFC |=> REG_RDATA == ifc_q)
		else $error("control readback wrong");
	AST_RD_STANDS: assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("read data moved");
endmodule // bertc_checker
bind bertc_core bertc_checker bertc_checker_inst (
	.CLK_SYS            (CLK_SYS),
	.SRST               (SRST),
	.REG_ADDR           (REG_ADDR),
	.REG_WR             (REG_WR),
	.REG_RD             (REG_RD),
	.REG_WDATA          (REG_WDATA),
	.REG_RDATA          (REG_RDATA),
	.LOOPBACK_EN        (LOOPBACK_EN),
	.TX_FBIT_SLOT       (TX_FBIT_SLOT),
	.LINE_TX_VALID      (LINE_TX_VALID),
	.BACKPLANE_RX_VALID (BACKPLANE_RX_VALID),
	.LINE_RX_STROBE     (LINE_RX_STROBE),
	.BACKPLANE_TX_STROBE(BACKPLANE_TX_STROBE),
	.RX_FBIT_SLOT       (RX_FBIT_SLOT),
	.CHECKER_IN_SYNC    (CHECKER_IN_SYNC)
);
`default_nettype wire

// file: tb/bertc_core_tb.sv
// Self-checking testbench of the bit-error-rate tester core
`timescale 1ns/1ns
`default_nettype none
`include "bertc_consts.vh"
module bertc_core_tb;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  wdata = 8'h00;
	logic        tx_fbit = 1'b0;
	logic        byte_start = 1'b0;
	logic        stall = 1'b0;
	logic        flip = 1'b0;
	logic        to_bp = 1'b0;
	logic        loop = 1'b0;
	logic        rx_fbit = 1'b0;
	wire  [7:0]  rdata;
	wire         ltd, ltv, btd, btv, ready, rxd, rxs, sync;
	int          errors = 0;
	int          samples_checked = 0;
	logic [31:0] v;
	logic [7:0]  c;
	localparam logic [31:0] PAT = 32'h5ad6b5ad;
	localparam logic [31:0] ALTP = 32'h7e7e5a00;
	localparam logic [39:0] ALT_SEQ = 40'h7e5a005a00;
	always #50 clk = ~clk;
	bertc_core bertc_core_inst (.CLK_SYS(clk), .SRST(srst), .REG_ADDR(addr), .REG_WR(wr),
		.REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .LOOPBACK_EN(loop),
		.TX_FBIT_SLOT(tx_fbit), .TX_BYTE_START(byte_start), .LINE_TX_DATA(ltd),
		.LINE_TX_VALID(ltv), .LINE_TX_READY(ready), .BACKPLANE_RX_SERIAL_OUT(btd),
		.BACKPLANE_RX_VALID(btv), .BACKPLANE_RX_READY(ready), .LINE_RX_DATA(rxd),
		.LINE_RX_STROBE(rxs & !to_bp), .BACKPLANE_TX_SERIAL_IN(rxd),
		.BACKPLANE_TX_STROBE(rxs & to_bp), .RX_FBIT_SLOT(rx_fbit), .CHECKER_IN_SYNC(sync));
	bertc_far_end bertc_far_end_inst (.clk(clk), .rst(srst), .stall(stall), .flip(flip),
		.tx_data(ltv ? ltd : btd), .tx_valid(ltv | btv), .ready(ready), .rx_data(rxd),
		.rx_strobe(rxs));
	task automatic test_done;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			#10;
		end
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		tick(1);
	endtask
	task automatic rd_cnt(input logic [7:0] a, input int n, output logic [31:0] r);
		r = 32'h0;
		rd = 1'b1;
		for (int i = 0; i < n; i++) begin
			addr = a + i[7:0];
			tick(1);
			r[8*i +: 8] = rdata;
		end
		rd = 1'b0;
		tick(1);
	endtask
	task automatic wait_sync;
		for (int i = 0; i < 300 && sync !== 1'b1; i++)
			tick(1);
		if (sync !== 1'b1) begin
			errors++;
			test_done;
		end
	endtask
	task automatic capture(input logic bp);
		int n;
		n = 0;
		for (int i = 0; i < 100 && n < 8; i++) begin
			if ((bp ? btv : ltv) === 1'b1) begin
				c = {bp ? btd : ltd, c[7:1]};
				n++;
			end
			tick(1);
		end
		if (n != 8) begin
			errors++;
			test_done;
		end
	endtask
	task automatic t_reset;
		for (int a = 'hdc; a <= 'hea; a++) begin
			rd_cnt(a[7:0], 1, v);
			chk(v, 32'h0);
		end
		rd_cnt(8'h10, 1, v);
		chk(v, 32'h0);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 4; i++)
			wr_reg(`BERTC_ADR_PAT0 + i[7:0], PAT[8*i +: 8]);
		wr_reg(`BERTC_ADR_BITC0, 8'hff);
		rd_cnt(`BERTC_ADR_PAT0, 4, v);
		chk(v, PAT);
		rd_cnt(`BERTC_ADR_BITC0, 1, v);
		chk(v, 32'h0);
	endtask
	task automatic t_line;
		wr_reg(`BERTC_ADR_IFC, 8'h01);
		capture(1'b0);
		chk(c, PAT[7:0]);
		wait_sync;
		chk(sync, 1'b1);
		rd_cnt(`BERTC_ADR_STATUS, 1, v);
		chk(v, 32'h1);
		stall = 1'b1;
		tick(4);
		wr_reg(`BERTC_ADR_CTRL_ONE, 8'h01);
		wr_reg(`BERTC_ADR_CTRL_ONE, 8'h00);
		rd_cnt(`BERTC_ADR_BITC0, 4, v);
		chk(v, 32'h0);
		stall = 1'b0;
		flip = 1'b1;
		tick(1);
		flip = 1'b0;
		tick(9);
		stall = 1'b1;
		tick(4);
		rd_cnt(`BERTC_ADR_BITC0, 4, v);
		chk(v, 32'h0000000a);
		rd_cnt(`BERTC_ADR_ERRC0, 3, v);
		chk(v, 32'h00000001);
		stall = 1'b0;
	endtask
	task automatic t_frame;
		tx_fbit = 1'b1;
		tick(3);
		chk(ltv, 1'b0);
		wr_reg(`BERTC_ADR_IFC, 8'h09);
		chk(ltv, 1'b1);
		tx_fbit = 1'b0;
	endtask
	task automatic t_align;
		wr_reg(`BERTC_ADR_IFC, 8'h01);
		wr_reg(`BERTC_ADR_IFC, 8'h11);
		tick(6);
		chk(ltv, 1'b0);
		byte_start = 1'b1;
		tick(1);
		byte_start = 1'b0;
		capture(1'b0);
		chk(c, PAT[7:0]);
	endtask
	task automatic t_bp;
		wr_reg(`BERTC_ADR_IFC, 8'h00);
		chk({ltv, btv, sync}, 32'h0);
		to_bp = 1'b1;
		wr_reg(`BERTC_ADR_IFC, 8'h03);
		capture(1'b1);
		chk(c, PAT[7:0]);
		chk(ltv, 1'b0);
		wait_sync;
		chk(sync, 1'b1);
	endtask
	task automatic t_modes;
		wr_reg(`BERTC_ADR_IFC, 8'h00);
		for (int i = 0; i < 4; i++)
			wr_reg(`BERTC_ADR_PAT0 + i[7:0], 8'hff);
		wr_reg(`BERTC_ADR_CTRL_ONE, 8'h04);
		wr_reg(`BERTC_ADR_IFC, 8'h03);
		capture(1'b1);
		chk(c, 32'hff);
		wait_sync;
		chk(sync, 1'b1);
		wr_reg(`BERTC_ADR_IFC, 8'h00);
		for (int i = 0; i < 4; i++)
			wr_reg(`BERTC_ADR_PAT0 + i[7:0], ALTP[8*i +: 8]);
		wr_reg(`BERTC_ADR_ALT_COUNT, 8'h02);
		wr_reg(`BERTC_ADR_CTRL_ONE, 8'h08);
		wr_reg(`BERTC_ADR_IFC, 8'h03);
		for (int k = 0; k < 5; k++) begin
			capture(1'b1);
			chk(c, ALT_SEQ[8*k +: 8]);
		end
	endtask
	task automatic t_loop;
		wr_reg(`BERTC_ADR_IFC, 8'h00);
		to_bp = 1'b0;
		loop = 1'b1;
		flip = 1'b1;
		wr_reg(`BERTC_ADR_IFC, 8'h01);
		wait_sync;
		chk(sync, 1'b1);
		rx_fbit = 1'b1;
		wr_reg(`BERTC_ADR_CTRL_ONE, 8'h09);
		wr_reg(`BERTC_ADR_CTRL_ONE, 8'h08);
		rd_cnt(`BERTC_ADR_BITC0, 4, v);
		chk(v, 32'h0);
		wr_reg(`BERTC_ADR_IFC, 8'h41);
		tick(4);
		stall = 1'b1;
		tick(2);
		rd_cnt(`BERTC_ADR_BITC0, 4, v);
		chk(v, 32'h5);
		stall = 1'b0;
		flip = 1'b0;
		loop = 1'b0;
		rx_fbit = 1'b0;
	endtask
	initial begin
		tick(4);
		srst = 1'b0;
		t_reset;
		t_regs;
		t_line;
		t_frame;
		t_align;
		t_bp;
		t_modes;
		t_loop;
		test_done;
	end
endmodule // bertc_core_tb
`default_nettype wire

// file: tb/bertc_far_end.sv
// Far-end model: sinks sent bits and returns them as received bits
`timescale 1ns/1ns
`default_nettype none
module bertc_far_end (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic stall,
	input  wire logic flip,
	input  wire logic tx_data,
	input  wire logic tx_valid,
	output logic      ready,
	output logic      rx_data,
	output logic      rx_strobe
);
	assign ready = !stall;
	// Taken bits come back in order one cycle later
	always @(posedge clk) begin
		rx_strobe <= !rst && tx_valid && ready;
		if (rst) begin
			rx_data <= 1'b0;
		end else if (tx_valid && ready) begin
			rx_data <= tx_data ^ flip;
		end else begin
			rx_data <= ~rx_data;
		end
	end
endmodule // bertc_far_end
`default_nettype wire
